// ===== hw/ppg_defs.svh
// Offsets, field positions, reset values and timing for the borrowed-pin GPIO bank
`ifndef PPG_DEFS_SVH
`define PPG_DEFS_SVH

`define PPG_IDX_OE          16'h4400
`define PPG_IDX_DIR         16'h4401
`define PPG_IDX_LEVEL       16'h4402
`define PPG_IDX_MUX         16'h4403
`define PPG_ADDR_OE         18'h11000
`define PPG_ADDR_DIR        18'h11004
`define PPG_ADDR_LEVEL      18'h11008
`define PPG_ADDR_MUX        18'h1100C
`define PPG_LINES           16
`define PPG_ADDR_PIN_LO     4
`define PPG_RST_OE          16'h0000
`define PPG_RST_DIR         16'h0000
`define PPG_RST_MUX         1'h1
`define PPG_MUX_GPIO        1'h0
`define PPG_CAPTURE_WAIT    2'h3

`endif

// ===== hw/ppg_pkg.sv
// Types shared by the borrowed-pin GPIO bank
`default_nettype none
package ppg_pkg;
  typedef logic [15:0] ppg_line_t;
  typedef enum logic [2:0] {
    PPG_IDLE   = 3'b001,
    PPG_ACCESS = 3'b010,
    PPG_DONE   = 3'b100
  } ppg_bus_e;
endpackage
`default_nettype wire

// ===== hw/ppg_sync.sv
// Two-stage synchroniser for the sixteen input pin levels
`default_nettype none
`include "ppg_defs.svh"
module ppg_sync (
  input  wire logic                  pclk,    // System clock
  input  wire logic                  presetn, // Async reset, active low
  input  wire ppg_pkg::ppg_line_t    raw,     // Pin levels from outside
  output var  ppg_pkg::ppg_line_t    synced   // Levels safe to read
);
  ppg_pkg::ppg_line_t stage1;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 16'h0000;
      synced <= 16'h0000;
    end else begin
      stage1 <= raw;
      synced <= stage1;
    end
  end
endmodule
`default_nettype wire

// ===== hw/ppg_gpio.sv
// Borrowed-pin GPIO bank 0 with APB register access
`default_nettype none
`include "ppg_defs.svh"
module ppg_gpio (
  input  wire logic         pclk,        // System clock, 100 MHz
  input  wire logic         presetn,     // Async reset, active low
  input  wire logic         psel,        // APB select
  input  wire logic         penable,     // APB access phase
  input  wire logic         pwrite,      // APB write
  input  wire logic [17:0]  paddr,       // APB byte address
  input  wire logic [31:0]  pwdata,      // APB write data
  output logic      [31:0]  prdata,      // APB read data
  output logic              pready,      // APB ready
  output logic              pslverr,     // APB error, unmapped address
  input  wire logic [3:0]   addr_pin_i,  // External address pins 21..18 in
  output logic      [3:0]   addr_pin_o,  // External address pins 21..18 out
  output logic      [3:0]   addr_pin_oe, // High while driving address pins
  input  wire logic [11:0]  data_pin_i,  // External data pins 27..16 in
  output logic      [11:0]  data_pin_o,  // External data pins 27..16 out
  output logic      [11:0]  data_pin_oe, // High while driving data pins
  output logic              gpio_mode    // High while pins are handed to GPIO
);
  ppg_pkg::ppg_line_t output_enable;
  ppg_pkg::ppg_line_t direction;
  ppg_pkg::ppg_line_t level_out;
  ppg_pkg::ppg_line_t pin_sync;
  ppg_pkg::ppg_line_t pin_raw;
  logic               mux_sel;
  logic [1:0]         capture_cnt;
  ppg_pkg::ppg_bus_e  bus_state;
  logic               wr_now;
  logic               rd_now;
  logic               hit;

  // Map byte address onto a register, returning a one-hot hit code
  function automatic logic [3:0] decode(input logic [17:0] a);
    decode = {a == `PPG_ADDR_MUX, a == `PPG_ADDR_LEVEL, a == `PPG_ADDR_DIR, a == `PPG_ADDR_OE};
  endfunction

  // Read view of the level register: inputs show pin, outputs show written value
  function automatic ppg_pkg::ppg_line_t level_view(input ppg_pkg::ppg_line_t dir,
                                                    input ppg_pkg::ppg_line_t drv,
                                                    input ppg_pkg::ppg_line_t pin);
    level_view = (dir & drv) | (~dir & pin);
  endfunction

  // Pin bundle in line order and the bus decode strobes
  assign pin_raw = {data_pin_i, addr_pin_i};
  assign hit     = |decode(paddr);
  assign wr_now  = (bus_state == ppg_pkg::PPG_ACCESS) && pwrite && hit;
  assign rd_now  = (bus_state == ppg_pkg::PPG_ACCESS) && !pwrite;

  ppg_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (pin_raw),
    .synced  (pin_sync)
  );

  // APB handshake: one wait state, pready a flop so every answer is registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= ppg_pkg::PPG_IDLE;
    end else begin
      case (bus_state)
        ppg_pkg::PPG_IDLE:   bus_state <= (psel && !penable) ? ppg_pkg::PPG_ACCESS : ppg_pkg::PPG_IDLE;
        ppg_pkg::PPG_ACCESS: bus_state <= ppg_pkg::PPG_DONE;
        ppg_pkg::PPG_DONE:   bus_state <= ppg_pkg::PPG_IDLE;
        default:             bus_state <= ppg_pkg::PPG_IDLE;
      endcase
    end
  end

  // Ready, error and read data, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= (bus_state == ppg_pkg::PPG_ACCESS);
      pslverr <= (bus_state == ppg_pkg::PPG_ACCESS) && !hit;
      if (rd_now) begin
        case (decode(paddr))
          4'h1:    prdata <= {16'h0000, output_enable};
          4'h2:    prdata <= {16'h0000, direction};
          4'h4:    prdata <= {16'h0000, level_view(direction, level_out, pin_sync)};
          4'h8:    prdata <= {31'h00000000, mux_sel};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Enable, direction and mux select registers; the write lands at the edge pready rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_enable <= `PPG_RST_OE;
      direction     <= `PPG_RST_DIR;
      mux_sel       <= `PPG_RST_MUX;
    end else if (wr_now) begin
      if (paddr == `PPG_ADDR_OE)  output_enable <= pwdata[15:0];
      if (paddr == `PPG_ADDR_DIR) direction     <= pwdata[15:0];
      if (paddr == `PPG_ADDR_MUX) mux_sel       <= pwdata[0];
    end
  end

  // Capture counter: level register loads pin state once synchroniser has filled
  // Counter parks at its top so the capture happens once per reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_cnt <= 2'h0;
    end else if (capture_cnt != `PPG_CAPTURE_WAIT) begin
      capture_cnt <= capture_cnt + 2'h1;
    end
  end

  // Level register: input lines track pin, written value held for outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_out <= 16'h0000;
    end else if (capture_cnt == 2'h2) begin
      level_out <= pin_sync;
    end else if (wr_now && paddr == `PPG_ADDR_LEVEL) begin
      level_out <= level_view(direction, pwdata[15:0], pin_sync);
    end else begin
      level_out <= level_view(direction, level_out, pin_sync);
    end
  end

  // Pin drivers; no drive at all unless the mux hands the pins to GPIO
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_pin_oe <= 4'h0;
      data_pin_oe <= 12'h000;
      addr_pin_o  <= 4'h0;
      data_pin_o  <= 12'h000;
      gpio_mode   <= 1'b0;
    end else begin
      gpio_mode   <= (mux_sel == `PPG_MUX_GPIO);
      {data_pin_oe, addr_pin_oe} <= (mux_sel == `PPG_MUX_GPIO) ? output_enable : 16'h0000;
      // Enabled input line drives its synchronised pin level back out; undefined is allowed there
      {data_pin_o, addr_pin_o}   <= level_out;
    end
  end

  // Assertions: pin drive follows enable and mux one flop late
  no_drive_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(output_enable) == 16'h0000) |-> ({data_pin_oe, addr_pin_oe} == 16'h0000))
    else $error("pin driven while its enable is clear");
  line_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (({data_pin_oe, addr_pin_oe} & ~$past(output_enable)) == 16'h0000))
    else $error("line driven while its own enable is clear");
  mux_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(mux_sel) |-> ({data_pin_oe, addr_pin_oe} == 16'h0000))
    else $error("pin driven while mux not in gpio mode");
  drive_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!mux_sel && output_enable == 16'hFFFF) |=> ({data_pin_oe, addr_pin_oe} == 16'hFFFF))
    else $error("enabled line not driven");

  // Level path: written value out to the pins, pin level back to reads
  out_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (direction == 16'hFFFF && wr_now && paddr == `PPG_ADDR_LEVEL)
    |=> ##1 ({data_pin_o, addr_pin_o} == $past(pwdata[15:0], 2)))
    else $error("written level not driven on pins");
  in_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_now && paddr == `PPG_ADDR_LEVEL && direction == 16'h0000)
    |=> (prdata[15:0] == $past(pin_sync)))
    else $error("input read does not show pin level");
  in_track_a: assert property (@(posedge pclk) disable iff (!presetn)
    (direction == 16'h0000 && capture_cnt == `PPG_CAPTURE_WAIT) |=> (level_out == $past(pin_sync)))
    else $error("input line level does not track its pin");

  // Synchroniser depth; the release edge is skipped since the flops are still held there
  sync_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |-> ##2 (pin_sync == $past(pin_raw, 2)))
    else $error("pin level not two flops late");
  reset_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    (capture_cnt == 2'h2) |=> (level_out == $past(pin_sync)))
    else $error("level register missed pin capture");
  dir_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (direction == 16'h0000))
    else $error("direction not zero after reset");
  oe_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_now && paddr == `PPG_ADDR_OE) |=> (output_enable == $past(pwdata[15:0])))
    else $error("enable write did not land bit for bit");

  // Bus answer shape: one wait state, single-cycle ready, error only with ready
  ready_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && bus_state == ppg_pkg::PPG_IDLE) |-> ##2 pready)
    else $error("pready not on time");
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");
  err_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error flag without ready");
  upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> (prdata[31:16] == 16'h0000))
    else $error("read data upper half not zero");

  // Main scenarios
  wr_cover_c: cover property (@(posedge pclk) disable iff (!presetn) wr_now && paddr == `PPG_ADDR_LEVEL);
  rd_cover_c: cover property (@(posedge pclk) disable iff (!presetn) rd_now && paddr == `PPG_ADDR_LEVEL);
  drive_cover_c: cover property (@(posedge pclk) disable iff (!presetn) |addr_pin_oe);
  err_cover_c: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  mux_cover_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(gpio_mode));
endmodule
`default_nettype wire

// ===== tb/ppg_board.sv
// Board model that drives the borrowed pins whenever the bank releases them
`default_nettype none
module ppg_board (
  input  wire logic [15:0] ext,         // Board level for lines 15..0
  input  wire logic [3:0]  addr_pin_o,  // Bank drive, address pins
  input  wire logic [3:0]  addr_pin_oe, // Bank enables, address pins
  input  wire logic [11:0] data_pin_o,  // Bank drive, data pins
  input  wire logic [11:0] data_pin_oe, // Bank enables, data pins
  output logic      [3:0]  addr_pin_i,  // Wire level, address pins
  output logic      [11:0] data_pin_i   // Wire level, data pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pin wins; the board never fights the bank on an enabled line
  assign addr_pin_i = (addr_pin_oe & addr_pin_o) | (~addr_pin_oe & ext[3:0]);
  assign data_pin_i = (data_pin_oe & data_pin_o) | (~data_pin_oe & ext[15:4]);
endmodule
`default_nettype wire

// ===== tb/ppg_gpio_tb_top.sv
// Self-checking bench for the borrowed-pin GPIO bank
`default_nettype none
`include "ppg_defs.svh"
module ppg_gpio_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, gpio_mode, err;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [3:0]  addr_pin_i, addr_pin_o, addr_pin_oe;
  logic [11:0] data_pin_i, data_pin_o, data_pin_oe;
  logic [15:0] ext, v, w;
  int          fails = 0, checks_done = 0, cyc = 0;

  ppg_gpio u_ppg_gpio (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .addr_pin_i(addr_pin_i), .addr_pin_o(addr_pin_o), .addr_pin_oe(addr_pin_oe), .data_pin_i(data_pin_i),
    .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe), .gpio_mode(gpio_mode));
  ppg_board u_ppg_board (.ext(ext), .addr_pin_o(addr_pin_o), .addr_pin_oe(addr_pin_oe),
    .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe), .addr_pin_i(addr_pin_i), .data_pin_i(data_pin_i));

  // Xorshift keeps the run repeatable without tool randomisation
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // One APB transfer; waits on pready with a bound
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    seed = 32'h27;
    ext = 16'hA5C3;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({data_pin_oe, addr_pin_oe, gpio_mode}, 32'h0);
    apb(1'b0, `PPG_ADDR_OE, 32'h0);
    chk(rd, {16'h0, `PPG_RST_OE});
    apb(1'b0, `PPG_ADDR_DIR, 32'h0);
    chk(rd, {16'h0, `PPG_RST_DIR});
    apb(1'b0, `PPG_ADDR_LEVEL, 32'h0);
    chk(rd, {16'h0, ext});
    // Unmapped word: data and error flag checked apart so neither is cut off
    apb(1'b0, 18'h11010, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `PPG_ADDR_MUX, 32'h0);
    // Read back also gives the registered mode flag time to follow the field
    apb(1'b0, `PPG_ADDR_MUX, 32'h0);
    chk(rd, {31'h0, `PPG_MUX_GPIO});
    chk({31'h0, gpio_mode}, 32'h1);
    // Random masks, first all inputs then all outputs
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : seed[15:0];
      seed = xs(seed);
      w = seed[15:0];
      ext <= seed[31:16];
      apb(1'b1, `PPG_ADDR_OE, {16'h0, v});
      apb(1'b1, `PPG_ADDR_DIR, {16'h0, v});
      apb(1'b1, `PPG_ADDR_LEVEL, {seed[31:16], w});
      apb(1'b0, `PPG_ADDR_DIR, 32'h0);
      chk(rd, {16'h0, v});
      apb(1'b0, `PPG_ADDR_LEVEL, 32'h0);
      chk(rd, {16'h0, (v & w) | (~v & ext)});
      chk({data_pin_oe, addr_pin_oe}, v);
      chk({data_pin_o, addr_pin_o} & v, w & v);
    end
    apb(1'b1, `PPG_ADDR_OE, 32'hFFFF);
    apb(1'b1, `PPG_ADDR_DIR, 32'hFFFF);
    apb(1'b1, `PPG_ADDR_MUX, 32'h1);
    repeat (3) @(posedge pclk);
    chk({data_pin_oe, addr_pin_oe, gpio_mode}, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
